// >>> include/spi_port_pkg.sv
// shared constants and carrier types of the serial peripheral port
package spi_port_pkg;

  // ------------------------------------------------------------
  // register offsets on the internal cpu bus
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h0a;
  localparam logic [7:0] ADDR_STATUS = 8'h0b;
  localparam logic [7:0] ADDR_DATA = 8'h0c;

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTL_RATE_LOW = 0;
  localparam int CTL_RATE_HIGH = 1;
  localparam int CTL_PHASE = 2;
  localparam int CTL_POLARITY = 3;
  localparam int CTL_MASTER = 4;
  localparam int CTL_WIRE_OR = 5;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_IRQ_ENABLE = 7;

  // ------------------------------------------------------------
  // status field positions and reset values
  // ------------------------------------------------------------
  localparam int ST_DONE = 7;
  localparam int ST_COLLISION = 6;
  localparam int ST_FAULT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ------------------------------------------------------------
  // master rate dividers of the processor clock
  // ------------------------------------------------------------
  localparam logic [5:0] DIV_CODE_00 = 6'h02;
  localparam logic [5:0] DIV_CODE_01 = 6'h04;
  localparam logic [5:0] DIV_CODE_10 = 6'h10;
  localparam logic [5:0] DIV_CODE_11 = 6'h20;

  // ------------------------------------------------------------
  // framing
  // ------------------------------------------------------------
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam int RX_FIFO_WIDTH = 8;
  localparam int RX_FIFO_DEPTH = 4;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spi_pins_out_t;

  typedef struct packed {
    logic ss_n;
    logic sck;
    logic mosi;
    logic miso;
  } spi_pins_in_t;

endpackage

// >>> design/spi_master_slave_port.sv
// serial peripheral port: receive fifo and master/slave byte engine
`timescale 1ns/1ps

// ------------------------------------------------------------
// receive fifo
// ------------------------------------------------------------
module spi_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_SLOT) ? '0 : p + PW'(1);
  endfunction

  assign in_ready = (s.count != FULL_COUNT);
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr = bump(s.wr_ptr);
    end
    if (pop)
    begin
      next_s.rd_ptr = bump(s.rd_ptr);
    end
    if (push && !pop)
    begin
      next_s.count = s.count + CW'(1);
    end
    else if (pop && !push)
    begin
      next_s.count = s.count - CW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

// ------------------------------------------------------------
// port engine
// ------------------------------------------------------------
// Function
// - one byte per eight clock pulses
// - slave takes sck as input only
// - master sck from processor clock, rate bits
// - master samples miso, drives mosi on sck
// - rate bits ignored in slave mode
// - select pin always input, low selects
// - deselected slave floats miso
// - deselected slave ignores sck and mosi
// - phase zero: first bit before first edge
// - phase zero: data writes blocked while selected
// - phase one: select may stay low
// - master seeing select low becomes slave
// - same event clears port enable
// - same event sets mode fault flag
// - master write starts clock and sequencer
// - master write loads shift register
// - finished byte copied to read buffer unless slave finds fifo full
// - slave starts on select low and sck
// - slave write loads shift register for miso
// - most significant bit first
// - rates divide by 2, 4, 16, 32
// - done flag set with read buffer copy
// - write during transfer sets collision unless done is set and unacknowledged, discarded
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire cpu_req_t bus,
  output logic [7:0] rdata,
  input wire spi_pins_in_t pins_in,
  output spi_pins_out_t pins_out
);

  typedef struct packed {
    logic [7:0] control;
    logic done_flag;
    logic coll_flag;
    logic fault_flag;
    logic arm_done;
    logic arm_coll;
    logic arm_fault;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic rx_push;
    logic [7:0] read_buffer;
    logic buffer_full;
    logic m_run;
    logic m_pend;
    logic [4:0] edge_cnt;
    logic [4:0] div_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] samp_d;
    logic [1:0] last_d;
    spi_pins_in_t sync1;
    spi_pins_in_t sync2;
    logic ss_prev;
    logic sck_prev;
    logic [7:0] rdata;
    spi_pins_out_t pins;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // half period in processor clocks for a rate code
  function automatic logic [4:0] half_period(input logic [1:0] code);
    logic [5:0] div;
    div = DIV_CODE_00;
    unique case (code)
      2'b00: div = DIV_CODE_00;
      2'b01: div = DIV_CODE_01;
      2'b10: div = DIV_CODE_10;
      2'b11: div = DIV_CODE_11;
    endcase
    half_period = div[5:1];
  endfunction

  spi_rx_fifo #(
    .WIDTH(RX_FIFO_WIDTH),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(s.rx_push),
    .in_data(s.rx_byte),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(!s.buffer_full)
  );

  assign rdata = s.rdata;
  assign pins_out = s.pins;

  always_comb
  begin
    logic enabled;
    logic master;
    logic phase;
    logic ss_low;
    logic sck_edge;
    logic leading;
    logic sample;
    logic slave_busy;
    logic data_wr;
    logic data_rd;
    logic [7:0] shifted;
    logic [7:0] filled;
    next_s = s;
    next_s.rx_push = 1'b0;
    next_s.samp_d = {s.samp_d[0], 1'b0};
    next_s.last_d = {s.last_d[0], 1'b0};
    // first stage feeds only the second
    next_s.sync1 = pins_in;
    next_s.sync2 = s.sync1;
    next_s.ss_prev = s.sync2.ss_n;
    next_s.sck_prev = s.sync2.sck;
    enabled = s.control[CTL_ENABLE];
    master = s.control[CTL_MASTER];
    phase = s.control[CTL_PHASE];
    ss_low = !s.sync2.ss_n;
    sck_edge = (s.sync2.sck != s.sck_prev);
    leading = (s.sync2.sck != s.control[CTL_POLARITY]);
    shifted = s.shreg;
    filled = s.shreg;
    sample = 1'b0;
    slave_busy = enabled && !master && ss_low && ((s.bit_cnt != '0) || !phase);
    data_wr = bus.wr && (bus.addr == ADDR_DATA);
    data_rd = bus.rd && (bus.addr == ADDR_DATA);

    // ------------------------------------------------------------
    // cpu reads and flag clearing
    // ------------------------------------------------------------
    next_s.rdata = BYTE_ZERO;
    if (bus.rd)
    begin
      unique case (bus.addr)
        ADDR_CONTROL: next_s.rdata = s.control;
        ADDR_STATUS:
        begin
          next_s.rdata[ST_DONE] = s.done_flag;
          next_s.rdata[ST_COLLISION] = s.coll_flag;
          next_s.rdata[ST_FAULT] = s.fault_flag;
          next_s.arm_done = s.done_flag;
          next_s.arm_coll = s.coll_flag;
          next_s.arm_fault = s.fault_flag;
        end
        ADDR_DATA: next_s.rdata = s.read_buffer;
        default: next_s.rdata = BYTE_ZERO;
      endcase
    end
    if (data_rd)
    begin
      next_s.buffer_full = 1'b0;
    end
    if (data_rd || data_wr)
    begin
      if (s.arm_done)
      begin
        next_s.done_flag = 1'b0;
      end
      if (s.arm_coll)
      begin
        next_s.coll_flag = 1'b0;
      end
      next_s.arm_done = 1'b0;
      next_s.arm_coll = 1'b0;
    end

    // ------------------------------------------------------------
    // cpu writes
    // ------------------------------------------------------------
    if (bus.wr && (bus.addr == ADDR_CONTROL))
    begin
      next_s.control = bus.wdata;
      if (s.arm_fault)
      begin
        next_s.fault_flag = 1'b0;
      end
      next_s.arm_fault = 1'b0;
      if (!bus.wdata[CTL_ENABLE] || !bus.wdata[CTL_MASTER])
      begin
        next_s.m_run = 1'b0;
        next_s.m_pend = 1'b0;
      end
    end
    // a write while done is set and unacknowledged is dropped silently
    if (data_wr && !(s.done_flag && !s.arm_done))
    begin
      if (s.m_run || s.m_pend || slave_busy || (s.samp_d != '0))
      begin
        next_s.coll_flag = 1'b1;
      end
      else
      begin
        next_s.shreg = bus.wdata;
        if (master && enabled)
        begin
          next_s.m_pend = 1'b1;
        end
      end
    end
    // late miso bit lands in slot zero, byte pushed once complete
    if (s.samp_d[1] && enabled && master)
    begin
      filled[0] = s.sync2.miso;
      next_s.shreg = filled;
      if (s.last_d[1])
      begin
        next_s.rx_byte = filled;
        next_s.rx_push = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // master engine
    // ------------------------------------------------------------
    if (enabled && master)
    begin
      // start waits for receive space so a finished byte is never lost
      if (s.m_pend && !s.m_run && fifo_in_ready)
      begin
        next_s.m_pend = 1'b0;
        next_s.m_run = 1'b1;
        next_s.edge_cnt = '0;
        next_s.div_cnt = '0;
        next_s.pins.sck_o = s.control[CTL_POLARITY];
        if (!phase)
        begin
          next_s.pins.mosi_o = s.shreg[7];
        end
      end
      else if (s.m_run)
      begin
        if (s.div_cnt == half_period(s.control[CTL_RATE_HIGH:CTL_RATE_LOW]) - 5'h01)
        begin
          next_s.div_cnt = '0;
          next_s.pins.sck_o = !s.pins.sck_o;
          next_s.edge_cnt = s.edge_cnt + 5'h01;
          sample = (s.edge_cnt[0] == 1'b0) ^ phase;
          if (sample)
          begin
            // miso is two cycles late through the synchroniser, fast rates included
            shifted = {filled[6:0], 1'b0};
            next_s.shreg = shifted;
            next_s.samp_d[0] = 1'b1;
            next_s.last_d[0] = (s.edge_cnt[4:1] == LAST_BIT);
          end
          else if (!(s.edge_cnt == LAST_EDGE && !phase))
          begin
            next_s.pins.mosi_o = s.shreg[7];
          end
          if (s.edge_cnt == LAST_EDGE)
          begin
            next_s.m_run = 1'b0;
          end
        end
        else
        begin
          next_s.div_cnt = s.div_cnt + 5'h01;
        end
      end
      // another party pulled our select low: give up mastership
      if (ss_low)
      begin
        next_s.control[CTL_MASTER] = 1'b0;
        next_s.control[CTL_ENABLE] = 1'b0;
        next_s.fault_flag = 1'b1;
        next_s.m_run = 1'b0;
        next_s.m_pend = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // slave engine, rate bits unused here
    // ------------------------------------------------------------
    if (enabled && !master)
    begin
      if (!ss_low)
      begin
        next_s.bit_cnt = '0;
      end
      else
      begin
        if (s.ss_prev && phase == 1'b0)
        begin
          next_s.pins.miso_o = s.shreg[7];
        end
        if (sck_edge)
        begin
          sample = leading ^ phase;
          if (sample)
          begin
            shifted = {s.shreg[6:0], s.sync2.mosi};
            next_s.shreg = shifted;
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == LAST_BIT)
            begin
              next_s.bit_cnt = '0;
              next_s.rx_byte = shifted;
              next_s.rx_push = fifo_in_ready;
            end
          end
          else
          begin
            next_s.pins.miso_o = s.shreg[7];
          end
        end
      end
    end
    else
    begin
      next_s.bit_cnt = '0;
    end

    // ------------------------------------------------------------
    // read buffer load with done flag, set beats any clear
    // ------------------------------------------------------------
    if (fifo_out_valid && !s.buffer_full)
    begin
      next_s.read_buffer = fifo_out_data;
      next_s.buffer_full = 1'b1;
      next_s.done_flag = 1'b1;
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    next_s.pins.sck_oe = next_s.control[CTL_ENABLE] && next_s.control[CTL_MASTER];
    next_s.pins.mosi_oe = next_s.pins.sck_oe;
    next_s.pins.miso_oe = next_s.control[CTL_ENABLE] && !next_s.control[CTL_MASTER]
      && !s.sync2.ss_n;
    if (!next_s.m_run)
    begin
      next_s.pins.sck_o = next_s.control[CTL_POLARITY];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.control <= CONTROL_RESET;
      s.sync1.ss_n <= 1'b1;
      s.sync2.ss_n <= 1'b1;
      s.ss_prev <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

// >>> verif/spi_port_chk.sv
// concurrent checks on the pins and bus of the serial peripheral port
`timescale 1ns/1ps
module spi_port_chk
  import spi_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire cpu_req_t bus,
  input wire logic [7:0] rdata,
  input wire spi_pins_in_t pins_in,
  input wire spi_pins_out_t pins_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // select input needs time to pass the synchroniser
  sequence ss_high_s;
    pins_in.ss_n [*5];
  endsequence
  sequence fault_s;
    $fell(pins_in.ss_n) && pins_out.sck_oe;
  endsequence

  miso_float_a: assert property (ss_high_s |-> !pins_out.miso_oe)
    else $error("miso driven while deselected");
  slave_clock_in_a: assert property (pins_out.miso_oe |-> !pins_out.sck_oe)
    else $error("slave drives the serial clock");
  master_mosi_a: assert property (pins_out.sck_oe |-> pins_out.mosi_oe)
    else $error("master clock without data output");
  fault_release_a: assert property (fault_s |-> ##[1:5] !pins_out.sck_oe)
    else $error("master kept driving after select fell");
  select_needed_a: assert property (pins_out.miso_oe |-> !$past(pins_in.ss_n, 2)
    || !$past(pins_in.ss_n, 3) || !$past(pins_in.ss_n, 4))
    else $error("miso driven without a low select");
  read_idle_a: assert property (!$past(bus.rd) |-> rdata == BYTE_ZERO)
    else $error("read data outside a read answer");
  unmapped_read_a: assert property (bus.rd && (bus.addr < ADDR_CONTROL
    || bus.addr > ADDR_DATA) |=> rdata == BYTE_ZERO)
    else $error("unmapped read returned data");
  status_layout_a: assert property ($past(bus.rd) && $past(bus.addr) == ADDR_STATUS
    |-> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
    else $error("status unused bits not zero");
endmodule

bind spi_master_slave_port spi_port_chk spi_port_chk_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .bus(bus),
  .rdata(rdata),
  .pins_in(pins_in),
  .pins_out(pins_out)
);

// >>> verif/spi_far_slave.sv
// behavioural far-side slave answering the port in master mode
`timescale 1ns/1ps
module spi_far_slave (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic clock_idle_polarity,
  input wire logic clock_phase_select,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  logic out_bit;

  always @(negedge ss_n)
  begin
    sh = tx;
    out_bit = tx[7];
  end

  always @(sck)
  begin
    if (!ss_n)
    begin
      if ((sck ^ clock_idle_polarity) ^ clock_phase_select)
      begin
        sh = {sh[6:0], mosi};
        rx = sh;
      end
      else
        out_bit = sh[7];
    end
  end

  // released line shows the inverse, so a stale bit never reads as data
  assign miso = ss_n ? ~out_bit : out_bit;
endmodule

// >>> verif/spi_master_slave_port_bench.sv
// self-checking bench of the serial peripheral port
`timescale 1ns/1ps
module spi_master_slave_port_bench
  import spi_port_pkg::*;
;
  logic clk_sys;
  logic rst;
  cpu_req_t bus;
  logic [7:0] rdata;
  spi_pins_in_t pins_in;
  spi_pins_out_t pins_out;
  logic dss_n, pss_n, bsck, bmosi, clock_idle_polarity, clock_phase_select, pmiso;
  logic [7:0] ptx, prx, q, st, d, m;
  logic [31:0] seed;
  int n_fail, checked, i, j, n;
  logic [7:0] exp_q[$];
  int half_t[4] = '{1, 2, 8, 16};
  wire logic sck_w = pins_out.sck_oe ? pins_out.sck_o : bsck;
  wire logic mosi_w = pins_out.mosi_oe ? pins_out.mosi_o : bmosi;
  wire logic miso_w = pins_out.miso_oe ? pins_out.miso_o : pmiso;
  assign pins_in = '{dss_n, sck_w, mosi_w, miso_w};

  spi_master_slave_port spi_master_slave_port_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .pins_in(pins_in),
    .pins_out(pins_out)
  );
  spi_far_slave spi_far_slave_inst (
    .sck(sck_w),
    .ss_n(pss_n),
    .mosi(mosi_w),
    .clock_idle_polarity(clock_idle_polarity),
    .clock_phase_select(clock_phase_select),
    .tx(ptx),
    .miso(pmiso),
    .rx(prx)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic close_out(input bit hung);
    if (hung)
      n_fail++;
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // one access: strobe held for one rising edge, answer read a half cycle later,
  // then one idle cycle so back-to-back calls never re-raise a strobe at once
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] v,
                     output logic [7:0] r);
    bus = '{addr: a, wr: w, rd: !w, wdata: v};
    @(negedge clk_sys);
    r = rdata;
    bus = '0;
    @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    acc(a, 1'b1, v, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] r;
    acc(a, 1'b0, 8'h00, r);
    chk(r, want);
  endtask

  task automatic wait_done(output logic [7:0] s);
    int t;
    t = 0;
    s = 8'h00;
    while (s[ST_DONE] !== 1'b1 && t < 2000)
    begin
      acc(ADDR_STATUS, 1'b0, 8'h00, s);
      t++;
    end
    if (s[ST_DONE] !== 1'b1)
      close_out(1);
  endtask

  task automatic sck_gap(output int g);
    logic s0;
    int t;
    t = 0;
    s0 = pins_out.sck_o;
    while (pins_out.sck_o === s0 && t < 99)
    begin
      @(negedge clk_sys);
      t++;
    end
    g = 0;
    s0 = pins_out.sck_o;
    while (pins_out.sck_o === s0 && g < 99)
    begin
      @(negedge clk_sys);
      g++;
    end
  endtask

  // bench as master, six processor cycles per half period
  task automatic mxfer(input logic [7:0] v, input logic ph, output logic [7:0] r);
    for (int b = 7; b >= 0; b--)
    begin
      if (!ph)
        bmosi = v[b];
      repeat (6) @(negedge clk_sys);
      bsck = ~bsck;
      if (ph)
        bmosi = v[b];
      else
        r[b] = miso_w;
      repeat (6) @(negedge clk_sys);
      bsck = ~bsck;
      if (ph)
        r[b] = miso_w;
    end
    repeat (6) @(negedge clk_sys);
    bmosi = ~bmosi;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    bus = '0;
    dss_n = 1'b1;
    pss_n = 1'b1;
    bsck = 1'b0;
    bmosi = 1'b0;
    clock_idle_polarity = 1'b0;
    clock_phase_select = 1'b0;
    ptx = 8'h00;
    n_fail = 0;
    checked = 0;
    seed = 32'h25a1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rc(ADDR_CONTROL, CONTROL_RESET);
    rc(ADDR_STATUS, BYTE_ZERO);
    rc(8'h0d, BYTE_ZERO);
    // master: every rate code, polarity and phase
    for (i = 0; i < 4; i++)
    begin
      clock_idle_polarity = i[1];
      clock_phase_select = i[0];
      wr(ADDR_CONTROL, {4'h5, i[1], i[0], i[1:0]});
      ptx = rnd();
      d = rnd();
      pss_n = 1'b0;
      wr(ADDR_DATA, d);
      wr(ADDR_DATA, ~d);
      sck_gap(n);
      chk(8'(n), 8'(half_t[i]));
      wait_done(st);
      chk(st, 8'hc0);
      rc(ADDR_DATA, ptx);
      chk(prx, d);
      rc(ADDR_STATUS, 8'h00);
      pss_n = 1'b1;
    end
    // slave, phase zero, rate bits set
    wr(ADDR_CONTROL, 8'h43);
    d = rnd();
    m = rnd();
    wr(ADDR_DATA, d);
    repeat (4)
    begin
      repeat (6) @(negedge clk_sys);
      bsck = ~bsck;
    end
    dss_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    wr(ADDR_DATA, 8'h00);
    mxfer(m, 1'b0, q);
    dss_n = 1'b1;
    chk(q, d);
    wait_done(st);
    chk(st, 8'hc0);
    rc(ADDR_DATA, m);
    // slave, phase one, select held low, receive fifo overflows
    wr(ADDR_CONTROL, 8'h44);
    dss_n = 1'b0;
    for (j = 0; j < 6; j++)
    begin
      m = rnd();
      mxfer(m, 1'b1, q);
      if (j < 5)
        exp_q.push_back(m);
    end
    dss_n = 1'b1;
    for (j = 0; j < 5; j++)
    begin
      wait_done(st);
      rc(ADDR_DATA, exp_q.pop_front());
    end
    rc(ADDR_STATUS, 8'h00);
    // mode fault in mid-transfer
    wr(ADDR_CONTROL, 8'h53);
    wr(ADDR_DATA, rnd());
    repeat (20) @(negedge clk_sys);
    dss_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rc(ADDR_STATUS, 8'h10);
    rc(ADDR_CONTROL, 8'h03);
    chk({7'h00, pins_out.sck_oe}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    dss_n = 1'b1;
    close_out(0);
  end
endmodule
